// ### rtl/ssps_status.v
// Operation
// [R1] Status register at 94h, bits INPUT_SAMPLE_PHASE CKE DA STOP START RW UA BF.
// [R2] I2C: data/address bit one after data byte, zero after address.
// [R3] I2C: stop flag set when last condition was stop; zero at reset.
// [R4] I2C: start flag set when last condition was start; zero at reset.
// [R5] Disable clears both flags; each condition clears the opposite flag.
// [R6] I2C: direction bit of last matching address captured in bit 2.
// [R7] Direction bit valid only from address match to next start/stop/ack.
// [R8] 10-bit I2C: update-address flag set when address must be rewritten.
// [R9] Clock-edge bit picks transmit edge; polarity one swaps the edges.
// [R10] Buffer-full: one after receive load or during transmit, else zero.
// [R11] SPI clock idles high when polarity is one, low when zero.
`timescale 1ns/1ns
`default_nettype none
`include "ssps_regs.vh"
module ssps_status
(
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Register port
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdData,
    // Serial link pins (outside domain)
    input  wire       sclPin,
    input  wire       sdaPin,
    // Datapath events (core domain)
    input  wire       byteDone,
    input  wire       byteIsData,
    input  wire       addrMatch,
    input  wire       addrRwBit,
    input  wire       ackSeen,
    input  wire       needAddrUpdate,
    input  wire       addrUpdated,
    input  wire       rxLoaded,
    input  wire       bufferRead,
    input  wire       txActive,
    // Configuration to datapath
    output wire       input_sample_phase,
    output wire       txOnRise,
    output wire       clockIdleLevel,
    output wire       port_enable_bit,
    output wire       rwValid,
    // Interrupt
    output wire       irq
);
    reg  [1:0] sclSync;
    reg  [1:0] sdaSync;
    reg        sclPrev;
    reg        sdaPrev;
    reg        sampleSel;
    reg        edgeSel;
    reg        dataFlag;
    reg        stopFlag;
    reg        startFlag;
    reg        rwFlag;
    reg        rwOk;
    reg        address_update_flag;
    reg        rxFull;
    reg  [7:0] control;
    reg  [3:0] irqStat;
    reg  [3:0] irqEn;
    wire       enabled;
    wire       i2cMode;
    wire       startEv;
    wire       stopEv;
    wire [7:0] serial_port_status;
    wire [3:0] events;
    wire [3:0] irqClr;
    wire       wrStatus;
    wire       wrControl;
    wire       wrIrqEn;
    wire       wrIrqClr;
    reg        next_dataFlag;
    reg        next_stopFlag;
    reg        next_startFlag;
    reg        next_rwFlag;
    reg        next_rwOk;
    reg        next_address_update_flag;
    reg        next_rxFull;
    reg  [3:0] next_irqStat;
    reg  [3:0] next_irqEn;
    reg  [7:0] next_rdData;

    // Number of interrupt sources
    localparam IRQ_COUNT = 4;

    assign enabled         = control[`SSPS_CTL_EN];
    assign i2cMode         = control[`SSPS_CTL_I2C] & enabled;
    assign port_enable_bit = enabled;
    // [R9] Edge select per polarity
    assign txOnRise = edgeSel ^ control[`SSPS_CTL_CKP];
    // [R11] Idle clock level
    assign clockIdleLevel = control[`SSPS_CTL_CKP];
    assign input_sample_phase = sampleSel;
    // [R7] Direction validity window
    assign rwValid = rwOk;

    // Pin synchronisers
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclSync <= {sclSync[0], sclPin};
            sdaSync <= {sdaSync[0], sdaPin};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end

    // Start: data falls while clock high; stop: data rises while clock high
    assign startEv = i2cMode & sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
    assign stopEv  = i2cMode & sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

    // Register write decode
    assign wrStatus  = regWr && (regAddr == `SSPS_ADDR_STATUS);
    assign wrControl = regWr && (regAddr == `SSPS_ADDR_CONTROL);
    assign wrIrqEn   = regWr && (regAddr == `SSPS_ADDR_IRQ_EN);
    assign wrIrqClr  = regWr && (regAddr == `SSPS_ADDR_IRQ_CLR);

    // [R1] Status layout
    assign serial_port_status = {sampleSel, edgeSel, dataFlag, stopFlag,
                                 startFlag, rwFlag, address_update_flag,
                                 rxFull | txActive};

    // Software-writable bits of the status register
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            sampleSel <= 1'b0;
            edgeSel   <= 1'b0;
        end
        else if (wrStatus)
        begin
            sampleSel <= regWrData[`SSPS_BIT_SMP];
            edgeSel   <= regWrData[`SSPS_BIT_CKE];
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
            control <= `SSPS_CONTROL_RST;
        else if (wrControl)
            control <= regWrData;
    end

    // [R2] Data or address byte
    always @*
    begin
        next_dataFlag = dataFlag;
        if (i2cMode && byteDone)
            next_dataFlag = byteIsData;
    end

    always @(posedge core_clk)
    begin
        if (rst)
            dataFlag <= 1'b0;
        else
            dataFlag <= next_dataFlag;
    end

    always @*
    begin
        next_stopFlag  = stopFlag;
        next_startFlag = startFlag;
        // [R5] Disable clears start and stop
        if (!enabled)
        begin
            next_stopFlag  = 1'b0;
            next_startFlag = 1'b0;
        end
        // [R3] Stop seen last
        else if (stopEv)
        begin
            next_stopFlag  = 1'b1;
            next_startFlag = 1'b0;
        end
        // [R4] Start seen last
        else if (startEv)
        begin
            next_stopFlag  = 1'b0;
            next_startFlag = 1'b1;
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            stopFlag  <= 1'b0;
            startFlag <= 1'b0;
        end
        else
        begin
            stopFlag  <= next_stopFlag;
            startFlag <= next_startFlag;
        end
    end

    always @*
    begin
        next_rwFlag = rwFlag;
        next_rwOk   = rwOk;
        // [R6] Capture direction on match
        if (i2cMode && addrMatch)
        begin
            next_rwFlag = addrRwBit;
            next_rwOk   = 1'b1;
        end
        // [R7] Window closes on start, stop or ack
        else if (startEv || stopEv || ackSeen || !i2cMode)
            next_rwOk = 1'b0;
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            rwFlag <= 1'b0;
            rwOk   <= 1'b0;
        end
        else
        begin
            rwFlag <= next_rwFlag;
            rwOk   <= next_rwOk;
        end
    end

    always @*
    begin
        next_address_update_flag = address_update_flag;
        // [R8] Address update request, set wins over clear
        if (i2cMode && control[`SSPS_CTL_A10] && needAddrUpdate)
            next_address_update_flag = 1'b1;
        else if (addrUpdated || !control[`SSPS_CTL_A10] || !i2cMode)
            next_address_update_flag = 1'b0;
    end

    always @(posedge core_clk)
    begin
        if (rst)
            address_update_flag <= 1'b0;
        else
            address_update_flag <= next_address_update_flag;
    end

    always @*
    begin
        next_rxFull = rxFull;
        // [R10] Receive buffer loaded until read
        if (rxLoaded)
            next_rxFull = 1'b1;
        else if (bufferRead)
            next_rxFull = 1'b0;
    end

    always @(posedge core_clk)
    begin
        if (rst)
            rxFull <= 1'b0;
        else
            rxFull <= next_rxFull;
    end

    // Interrupt events: stop, start, byte done, update request
    assign events = {i2cMode & control[`SSPS_CTL_A10] & needAddrUpdate,
                     byteDone, startEv, stopEv};
    assign irqClr = wrIrqClr ? regWrData[3:0] : 4'h0;
    assign irq = |(irqStat & irqEn);

    genvar i;
    generate
        for (i = 0; i < IRQ_COUNT; i = i + 1)
        begin : gIrq
            // Sticky event bit, set wins over clear
            always @*
            begin
                next_irqStat[i] = irqStat[i];
                if (events[i])
                    next_irqStat[i] = 1'b1;
                else if (irqClr[i])
                    next_irqStat[i] = 1'b0;
            end

            always @(posedge core_clk)
            begin
                if (rst)
                    irqStat[i] <= 1'b0;
                else
                    irqStat[i] <= next_irqStat[i];
            end
        end
    endgenerate

    always @*
    begin
        next_irqEn = irqEn;
        if (wrIrqEn)
            next_irqEn = regWrData[3:0];
    end

    always @(posedge core_clk)
    begin
        if (rst)
            irqEn <= 4'h0;
        else
            irqEn <= next_irqEn;
    end

    // Read data one cycle after strobe, zero otherwise
    always @*
    begin
        case (regAddr)
            `SSPS_ADDR_STATUS:   next_rdData = serial_port_status;
            `SSPS_ADDR_CONTROL:  next_rdData = control;
            `SSPS_ADDR_IRQ_STAT: next_rdData = {4'h0, irqStat};
            `SSPS_ADDR_IRQ_EN:   next_rdData = {4'h0, irqEn};
            default:             next_rdData = 8'h00;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (rst || !regRd)
            regRdData <= 8'h00;
        else
            regRdData <= next_rdData;
    end
endmodule // ssps_status
`default_nettype wire

// ### rtl/ssps_regs.vh
`ifndef SSPS_REGS_VH
`define SSPS_REGS_VH
// Register addresses (8-bit data-memory map)
`define SSPS_ADDR_STATUS   8'h94
`define SSPS_ADDR_CONTROL  8'h95
`define SSPS_ADDR_IRQ_STAT 8'h96
`define SSPS_ADDR_IRQ_EN   8'h97
`define SSPS_ADDR_IRQ_CLR  8'h98
// Status bit positions
`define SSPS_BIT_SMP  7
`define SSPS_BIT_CKE  6
`define SSPS_BIT_DA   5
`define SSPS_BIT_STOP 4
`define SSPS_BIT_STRT 3
`define SSPS_BIT_RW   2
`define SSPS_BIT_UA   1
`define SSPS_BIT_BF   0
// Control bit positions
`define SSPS_CTL_EN   0
`define SSPS_CTL_CKP  1
`define SSPS_CTL_I2C  2
`define SSPS_CTL_A10  3
// Interrupt event bit positions
`define SSPS_IRQ_STOP 0
`define SSPS_IRQ_STRT 1
`define SSPS_IRQ_BYTE 2
`define SSPS_IRQ_UA   3
// Reset values
`define SSPS_STATUS_RST  8'h00
`define SSPS_CONTROL_RST 8'h00
`endif

// ### verif/ssps_status_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ssps_status_properties
(
    // Clock, reset and register port
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // Events and configuration outputs
    input wire logic       addrMatch,
    input wire logic       ackSeen,
    input wire logic       txActive,
    input wire logic       rwValid,
    input wire logic       input_sample_phase,
    input wire logic       txOnRise,
    input wire logic       clockIdleLevel,
    input wire logic       irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_phase_write: assert property (regWr && regAddr == 8'h94 |=>
        input_sample_phase == $past(regWrData[7])) else $error("phase");
    a_edge_select: assert property (regWr && regAddr == 8'h94 |=>
        txOnRise == ($past(regWrData[6]) ^ clockIdleLevel)) else $error("edge");
    a_idle_level: assert property (regWr && regAddr == 8'h95 |=>
        clockIdleLevel == $past(regWrData[1])) else $error("idle level");
    a_read_quiet: assert property (!regRd |=>
        regRdData == 8'h00) else $error("read data not idle");
    a_buffer_tx: assert property (regRd && regAddr == 8'h94 && txActive |=>
        regRdData[0]) else $error("buffer full");
    a_rw_open: assert property (addrMatch |=> rwValid)
        else $error("direction not valid");
    a_rw_close: assert property (ackSeen && !addrMatch |=> !rwValid)
        else $error("direction still valid");
    a_irq_masked: assert property (regWr && regAddr == 8'h97 &&
        regWrData == 8'h00 |=> !irq) else $error("masked irq");
endmodule // ssps_status_properties
bind ssps_status ssps_status_properties chk (.*);
`default_nettype wire

// ### verif/ssps_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module ssps_i2c_master
(
    // Bus lines, pulled high when released
    output var logic sclPin,
    output var logic sdaPin
);
    initial {sclPin, sdaPin} = 2'b11;
    task start_cond;
        sdaPin = 1'b1;
        #80 sclPin = 1'b1;
        #80 sdaPin = 1'b0;
        #80 sclPin = 1'b0;
    endtask
    task stop_cond;
        sdaPin = 1'b0;
        #80 sclPin = 1'b1;
        #80 sdaPin = 1'b1;
        #80;
    endtask
endmodule // ssps_i2c_master
`default_nettype wire

// ### verif/ssps_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ssps_status_tb;
    logic        core_clk, rst, regWr, regRd, txActive, irq, scl, sda, lvl;
    logic [7:0]  regAddr, regWrData, regRdData, rdv;
    logic [6:0]  pv;
    logic        txr, idl, ena, rwv;
    int          err_count, tests_run, i;
    logic [31:0] rows [4] = '{32'h9AFF9400, 32'h94FF94C0, 32'h99FF9900,
                              32'h94409440};
    ssps_status uut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .sclPin(scl), .sdaPin(sda), .byteDone(pv[2]),
        .byteIsData(lvl), .addrMatch(pv[0]), .addrRwBit(lvl), .ackSeen(pv[1]),
        .needAddrUpdate(pv[3]), .addrUpdated(pv[4]), .rxLoaded(pv[5]),
        .bufferRead(pv[6]), .txActive(txActive), .input_sample_phase(),
        .txOnRise(txr), .clockIdleLevel(idl), .port_enable_bit(ena),
        .rwValid(rwv), .irq(irq));
    ssps_i2c_master m (.sclPin(scl), .sdaPin(sda));
    task chk(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge core_clk) {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge core_clk) regWr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk) {regAddr, regRd} <= {a, 1'b1};
        @(posedge core_clk) regRd <= 1'b0;
        #1 rdv = regRdData;
    endtask
    // Bit 7 sets the direction/data level, the rest pulse one cycle
    task ev(input logic [7:0] v);
        @(posedge core_clk) {lvl, pv} <= v;
        @(posedge core_clk) pv <= 7'h00;
    endtask
    task report_and_stop;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (50000) @(posedge core_clk);
        err_count++;
        report_and_stop;
    end
    initial
    begin
        {rst, regWr, regRd, txActive, lvl, pv} = 12'h800;
        {regAddr, regWrData} = 16'h0000;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            wr(rows[i][31:24], rows[i][23:16]);
            rd(rows[i][15:8]);
            chk("row", rdv, rows[i][7:0]);
        end
        wr(8'h95, 8'h05);
        chk("enable", {7'h00, ena}, 8'h01);
        chk("tx edge low", {7'h00, txr}, 8'h01);
        chk("idle low", {7'h00, idl}, 8'h00);
        wr(8'h97, 8'h01);
        m.start_cond();
        ev(8'h01);
        ev(8'h04);
        rd(8'h94);
        chk("address byte", rdv, 8'h48);
        chk("rw open", {7'h00, rwv}, 8'h01);
        ev(8'h81);
        ev(8'h82);
        ev(8'h84);
        @(posedge core_clk) txActive <= 1'b1;
        rd(8'h94);
        chk("data byte", rdv, 8'h6D);
        chk("rw closed", {7'h00, rwv}, 8'h00);
        @(posedge core_clk) txActive <= 1'b0;
        ev(8'hA0);
        rd(8'h94);
        chk("rx full", rdv, 8'h6D);
        ev(8'hC0);
        m.stop_cond();
        rd(8'h94);
        chk("stop", rdv, 8'h74);
        chk("irq set", {7'h00, irq}, 8'h01);
        wr(8'h98, 8'h01);
        chk("irq clear", {7'h00, irq}, 8'h00);
        wr(8'h95, 8'h0F);
        chk("tx edge high", {7'h00, txr}, 8'h00);
        chk("idle high", {7'h00, idl}, 8'h01);
        ev(8'h88);
        rd(8'h94);
        chk("update", rdv, 8'h76);
        ev(8'h90);
        m.start_cond();
        rd(8'h94);
        chk("restart", rdv, 8'h6C);
        wr(8'h95, 8'h00);
        rd(8'h94);
        chk("disable", rdv & 8'h18, 8'h00);
        chk("enable off", {7'h00, ena}, 8'h00);
        wr(8'h97, 8'h0F);
        chk("irq pending", {7'h00, irq}, 8'h01);
        wr(8'h97, 8'h00);
        chk("irq masked", {7'h00, irq}, 8'h00);
        repeat (2) @(posedge core_clk);
        report_and_stop;
    end
endmodule // ssps_status_tb
`default_nettype wire
